// File: logic/prv_pkg.sv
package prv_pkg;

	// ==========================================================
	// Clock and timing
	localparam int          CLK_PERIOD_NS      = 100;
	localparam int          IORDY_PULSE_MAX_NS = 1250;
	localparam int          IORDY_SETUP_NS     = 35;
	// Longest time rounds down to whole cycles
	localparam logic [3:0]  WAIT_MAX_CYC       = 4'(IORDY_PULSE_MAX_NS / CLK_PERIOD_NS);

	// ==========================================================
	// Transfer modes
	localparam logic [2:0]  MODE_BOOT          = 3'h0;
	localparam logic [2:0]  MODE_SLOW_MAX      = 3'h2;
	localparam logic [2:0]  MODE_FAST_MIN      = 3'h3;
	localparam logic [2:0]  MODE_MAX           = 3'h4;

	// ==========================================================
	// Reported cycle time (ns)
	localparam logic [15:0] T0_MODE3_NS        = 16'h00B4;
	localparam logic [15:0] T0_MODE4_NS        = 16'h0078;
	localparam logic [15:0] DEV_CYCLE_NS       = 16'h0078;

	// ==========================================================
	// Synchronised pin bundle layout
	localparam int          SYNC_W             = 16;
	localparam int          SB_DD_LSB          = 0;
	localparam int          SB_DA_LSB          = 8;
	localparam int          SB_CS0             = 11;
	localparam int          SB_CS1             = 12;
	localparam int          SB_RD              = 13;
	localparam int          SB_WR              = 14;
	localparam int          SB_ACK             = 15;
	localparam logic [15:0] SYNC_RST           = 16'hFF00;

	// ==========================================================
	// Reset values
	localparam logic [7:0]  DATA_RST           = 8'h00;
	localparam logic [4:0]  ADDR_RST           = 5'h1F;
	localparam logic [3:0]  CNT_RST            = 4'h0;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_READ  = 4'h2,
		ST_WRITE = 4'h4,
		ST_HOLD  = 4'h8
	} prv_state_type;

endpackage : prv_pkg

// File: logic/prv_sync.sv
`timescale 1ns/1ps
module prv_sync #(
	parameter int               W       = 1,
	parameter logic [W-1:0]     RST_VAL = '0
) (
	input  wire logic           core_clk,
	input  wire logic           rst_n,
	input  wire logic [W-1:0]   async_in,
	output logic      [W-1:0]   sync_out
);

	// ==========================================================
	// Two-stage synchroniser; first stage feeds only the second
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule : prv_sync

// File: logic/prv_reg_port.sv
`timescale 1ns/1ps
module prv_reg_port
	import prv_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        cs0_n_pin,
	input  wire logic        cs1_n_pin,
	input  wire logic [2:0]  da_pin,
	input  wire logic        dior_n_pin,
	input  wire logic        diow_n_pin,
	input  wire logic        dmack_n_pin,
	input  wire logic [7:0]  dd_in,
	output logic      [7:0]  dd_out,
	output logic             dd_oe,
	output logic             iordy_out,
	output logic             iordy_oe,
	output logic      [4:0]  reg_addr,
	output logic             reg_rd,
	output logic             reg_wr,
	output logic      [7:0]  reg_wdata,
	input  wire logic [7:0]  reg_rdata,
	input  wire logic        reg_rvalid,
	input  wire logic        mode_wr,
	input  wire logic [2:0]  mode_val,
	output logic      [2:0]  cur_mode,
	output logic      [15:0] id_word68
);
	import prv_pkg::*;

	// ==========================================================
	// Pin synchronisation
	logic [SYNC_W-1:0] pin_bus;
	logic [SYNC_W-1:0] sb;

	assign pin_bus = {dmack_n_pin, diow_n_pin, dior_n_pin, cs1_n_pin, cs0_n_pin, da_pin, dd_in};

	prv_sync #(
		.W       (SYNC_W),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in (pin_bus),
		.sync_out (sb)
	);

	// ==========================================================
	// Decode
	prv_state_type state_ff;
	prv_state_type nxt_state;
	logic [2:0]    mode_ff;
	logic          mode_set_ff;
	logic [15:0]   word68_ff;
	logic [7:0]    dd_out_ff;
	logic          dd_oe_ff;
	logic          iordy_oe_ff;
	logic [3:0]    wait_cnt_ff;
	logic          park_ff;
	logic [4:0]    addr_ff;
	logic          rd_ff;
	logic          wr_ff;
	logic [7:0]    wdata_ff;

	wire        dmack_idle  = sb[SB_ACK];
	wire        rd_act      = !sb[SB_RD] && dmack_idle;
	wire        wr_act      = !sb[SB_WR] && dmack_idle;
	wire        selected    = !sb[SB_CS0] || !sb[SB_CS1];
	wire [4:0]  sb_addr     = {sb[SB_CS1], sb[SB_CS0], sb[SB_DA_LSB +: 3]};
	wire [7:0]  sb_data     = sb[SB_DD_LSB +: 8];
	wire        wait_en     = mode_ff >= MODE_FAST_MIN;
	wire        wait_lim    = wait_cnt_ff == (WAIT_MAX_CYC - 4'h1);
	wire        read_done   = reg_rvalid || wait_lim || !rd_act;
	wire        mode_ok     = mode_val <= MODE_MAX;

	// ==========================================================
	// Cycle sequencer
	// Strobe ends are taken from the synchronised level, so any
	// stretch of either phase is followed without a fixed shape.
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (rd_act) begin
					nxt_state = ST_READ;
				end else if (wr_act) begin
					nxt_state = ST_WRITE;
				end
			end
			ST_READ: begin
				if (read_done) begin
					nxt_state = ST_HOLD;
				end
			end
			ST_WRITE: begin
				if (!wr_act) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_HOLD: begin
				if (!rd_act) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// In fast modes IORDY is pre-negated while the device is selected, because the
	// 35 ns sampling point is shorter than one clock. It is only ever
	// pulled low or floated, so it is never driven asserted at all.
	wire nxt_iordy_oe = wait_en && !park_ff && !wait_lim &&
	                    ((nxt_state == ST_IDLE && selected) || nxt_state == ST_READ);
	wire nxt_park     = wait_lim ? 1'b1 : (state_ff == ST_IDLE && !selected) ? 1'b0 : park_ff;
	wire start_rd     = state_ff == ST_IDLE && nxt_state == ST_READ;
	wire start_wr     = state_ff == ST_IDLE && nxt_state == ST_WRITE;
	wire nxt_dd_oe    = nxt_state == ST_READ || nxt_state == ST_HOLD;
	wire load_rdata   = state_ff == ST_READ && reg_rvalid;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff    <= ST_IDLE;
			iordy_oe_ff <= 1'b0;
			park_ff     <= 1'b0;
			wait_cnt_ff <= CNT_RST;
			dd_oe_ff    <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			iordy_oe_ff <= nxt_iordy_oe;
			park_ff     <= nxt_park;
			// Restart at the limit so the count never passes the pulse ceiling
			wait_cnt_ff <= (iordy_oe_ff && !wait_lim) ? wait_cnt_ff + 4'h1 : CNT_RST;
			dd_oe_ff    <= nxt_dd_oe;
		end
	end

	// ==========================================================
	// Data path
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dd_out_ff <= DATA_RST;
			addr_ff   <= ADDR_RST;
			rd_ff     <= 1'b0;
			wr_ff     <= 1'b0;
			wdata_ff  <= DATA_RST;
		end else begin
			rd_ff <= start_rd;
			wr_ff <= state_ff == ST_WRITE && !wr_act;
			if (start_rd || start_wr) begin
				addr_ff <= sb_addr;
			end
			if (load_rdata) begin
				dd_out_ff <= reg_rdata;
			end
			if (wr_act) begin
				wdata_ff <= sb_data;
			end
		end
	end

	// ==========================================================
	// Mode and identification
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff     <= MODE_BOOT;
			mode_set_ff <= 1'b0;
			word68_ff   <= DEV_CYCLE_NS;
		end else begin
			if (mode_wr && mode_ok) begin
				mode_ff     <= mode_val;
				mode_set_ff <= 1'b1;
			end
		end
	end

	assign dd_out    = dd_out_ff;
	assign dd_oe     = dd_oe_ff;
	assign iordy_out = 1'b0;
	assign iordy_oe  = iordy_oe_ff;
	assign reg_addr  = addr_ff;
	assign reg_rd    = rd_ff;
	assign reg_wr    = wr_ff;
	assign reg_wdata = wdata_ff;
	assign cur_mode  = mode_ff;
	assign id_word68 = word68_ff;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_write_strobe;
		state_ff == ST_WRITE && wr_act ##1 !wr_act;
	endsequence

	sequence s_read_release;
		state_ff == ST_READ && reg_rvalid ##1 !iordy_oe_ff;
	endsequence

	a_boot_slow_mode: assert property (!mode_set_ff |-> mode_ff <= MODE_SLOW_MAX)
		else $error("mode left boot range without a mode write");
	a_word68_mode4: assert property (word68_ff >= T0_MODE4_NS)
		else $error("reported cycle time below mode 4 minimum");
	a_word68_fast: assert property (mode_ff >= MODE_FAST_MIN |-> word68_ff >= T0_MODE4_NS &&
	                                word68_ff == id_word68)
		else $error("word 68 not published in fast mode");
	a_slow_no_wait: assert property (mode_ff < MODE_FAST_MIN |-> !iordy_oe_ff)
		else $error("IORDY negated in a slow mode");
	a_wait_bounded: assert property (wait_cnt_ff < WAIT_MAX_CYC)
		else $error("IORDY held negated beyond pulse limit");
	a_never_drive_hi: assert property (iordy_oe_ff |-> !iordy_out)
		else $error("IORDY driven asserted");
	a_read_data_first: assert property (s_read_release |-> dd_oe_ff &&
	                                    dd_out_ff == $past(reg_rdata))
		else $error("IORDY released before read data valid");
	a_write_pulse: assert property (s_write_strobe |=> reg_wr ##1 !reg_wr)
		else $error("write strobe end gave no single write pulse");
	a_dmack_ignored: assert property (state_ff == ST_IDLE && !sb[SB_ACK] |=> !reg_rd &&
	                                  state_ff == ST_IDLE)
		else $error("strobe taken while DMACK- asserted");
	a_no_wait_release: assert property (state_ff == ST_HOLD |-> !iordy_oe_ff)
		else $error("IORDY still negated after read serviced");

endmodule : prv_reg_port

// File: test/prv_host_model.sv
`timescale 1ns/1ps
module prv_host_model (
	input  wire logic       core_clk,
	output logic            cs0_n_pin,
	output logic            cs1_n_pin,
	output logic      [2:0] da_pin,
	output logic            dior_n_pin,
	output logic            diow_n_pin,
	output logic            dmack_n_pin,
	output logic      [7:0] dd_in,
	input  wire logic [7:0] dd_out,
	input  wire logic       dd_oe,
	input  wire logic       iordy_out,
	input  wire logic       iordy_oe
);
	logic       iordy;
	logic [7:0] host_dd;

	// Pull-up on the wire; a released data bus shows what the host drives
	assign iordy = iordy_oe ? iordy_out : 1'b1;
	assign dd_in = dd_oe ? dd_out : host_dd;

	initial begin
		{cs1_n_pin, cs0_n_pin, dior_n_pin, diow_n_pin, dmack_n_pin} <= 5'h1F;
		da_pin  <= 3'h0;
		host_dd <= 8'h00;
	end

	// ==========================================================
	// One register cycle
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] wd,
		input int wid, input logic ack_n, output logic [7:0] q, output int waits);
		waits = 0;
		@(posedge core_clk);
		{cs1_n_pin, cs0_n_pin, da_pin} <= a;
		dmack_n_pin <= ack_n;
		host_dd <= wd;
		// Long address setup also gives the device time to pre-negate IORDY
		repeat (3) @(posedge core_clk);
		dior_n_pin <= !rd;
		diow_n_pin <= rd;
		repeat (wid) @(posedge core_clk);
		#1;
		while (iordy !== 1'b1 && waits < 40) begin
			@(posedge core_clk);
			#1;
			waits++;
		end
		q = dd_in;
		@(posedge core_clk);
		{dior_n_pin, diow_n_pin} <= 2'h3;
		@(posedge core_clk);
		{cs1_n_pin, cs0_n_pin, dmack_n_pin} <= 3'h7;
		host_dd <= ~wd;
		repeat (3) @(posedge core_clk);
	endtask : xfer
endmodule : prv_host_model

// File: test/tb_pio_register_transfer_timing.sv
`timescale 1ns/1ps
module tb_pio_register_transfer_timing;
	import prv_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_n    = 1'b0;
	logic        cs0_n_pin, cs1_n_pin, dior_n_pin, diow_n_pin, dmack_n_pin;
	logic        dd_oe, iordy_out, iordy_oe, reg_rd, reg_wr;
	logic        reg_rvalid = 1'b0;
	logic        mode_wr    = 1'b0;
	logic [2:0]  mode_val   = 3'h0;
	logic [2:0]  da_pin, cur_mode;
	logic [7:0]  reg_rdata  = 8'h00;
	logic [7:0]  dd_in, dd_out, reg_wdata, q, wr_data;
	logic [4:0]  reg_addr, wr_addr, rd_addr;
	logic [15:0] id_word68;
	int          num_errors = 0;
	int          tests_run  = 0;
	int          cyc = 0;
	int          rd_cnt = 0;
	int          wr_cnt = 0;
	int          rv_cnt = 0;
	int          rv_dly = 1;
	int          waits;

	prv_reg_port dut (
		.core_clk    (core_clk),
		.rst_n       (rst_n),
		.cs0_n_pin   (cs0_n_pin),
		.cs1_n_pin   (cs1_n_pin),
		.da_pin      (da_pin),
		.dior_n_pin  (dior_n_pin),
		.diow_n_pin  (diow_n_pin),
		.dmack_n_pin (dmack_n_pin),
		.dd_in       (dd_in),
		.dd_out      (dd_out),
		.dd_oe       (dd_oe),
		.iordy_out   (iordy_out),
		.iordy_oe    (iordy_oe),
		.reg_addr    (reg_addr),
		.reg_rd      (reg_rd),
		.reg_wr      (reg_wr),
		.reg_wdata   (reg_wdata),
		.reg_rdata   (reg_rdata),
		.reg_rvalid  (reg_rvalid),
		.mode_wr     (mode_wr),
		.mode_val    (mode_val),
		.cur_mode    (cur_mode),
		.id_word68   (id_word68)
	);
	prv_host_model host (
		.core_clk    (core_clk),
		.cs0_n_pin   (cs0_n_pin),
		.cs1_n_pin   (cs1_n_pin),
		.da_pin      (da_pin),
		.dior_n_pin  (dior_n_pin),
		.diow_n_pin  (diow_n_pin),
		.dmack_n_pin (dmack_n_pin),
		.dd_in       (dd_in),
		.dd_out      (dd_out),
		.dd_oe       (dd_oe),
		.iordy_out   (iordy_out),
		.iordy_oe    (iordy_oe)
	);

	initial begin
		forever #50 core_clk = ~core_clk;
	end

	// ==========================================================
	// Register user side and run limit
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		rv_cnt <= reg_rd ? rv_dly : (rv_cnt > 0 ? rv_cnt - 1 : 0);
		reg_rvalid <= (rv_cnt == 1);
		if (reg_rd) begin
			rd_cnt <= rd_cnt + 1;
			rd_addr <= reg_addr;
		end
		if (reg_wr) begin
			wr_cnt <= wr_cnt + 1;
			wr_addr <= reg_addr;
			wr_data <= reg_wdata;
		end
		if (cyc == 6000) begin
			num_errors++;
			end_sim();
		end
	end

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic end_sim;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic set_mode(input logic [2:0] m, input logic [2:0] exp);
		@(posedge core_clk);
		mode_wr <= 1'b1;
		mode_val <= m;
		@(posedge core_clk);
		mode_wr <= 1'b0;
		@(posedge core_clk);
		#1;
		check("cur_mode", {13'h0, cur_mode}, {13'h0, exp});
	endtask : set_mode

	// Reads put the inverse on the host side so stale data cannot pass
	task automatic run(input logic rd, input logic [4:0] a, input logic [7:0] d,
		input int wid, input int dly, input logic ack_n);
		@(posedge core_clk);
		reg_rdata <= d;
		rv_dly <= dly;
		host.xfer(rd, a, rd ? ~d : d, wid, ack_n, q, waits);
		repeat (3) @(posedge core_clk);
		#1;
	endtask : run

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		check("boot_mode", {13'h0, cur_mode}, {13'h0, MODE_BOOT});
		check("id68_floor", {15'h0, id_word68 >= T0_MODE4_NS}, 16'h1);
		check("oe_idle", {14'h0, dd_oe, iordy_oe}, 16'h0);
	endtask : t_reset

	task automatic t_slow;
		run(1'b0, 5'h15, 8'hA5, 8, 1, 1'b1);
		check("wr_cnt", 16'(wr_cnt), 16'h1);
		check("wr_word", {3'h0, wr_addr, wr_data}, 16'h15A5);
		run(1'b1, 5'h0E, 8'h3C, 8, 1, 1'b1);
		check("rd_data", {8'h0, q}, 16'h003C);
		check("rd_waits", 16'(waits), 16'h0);
		check("rd_cnt", 16'(rd_cnt), 16'h1);
		check("rd_addr", {11'h0, rd_addr}, 16'h000E);
	endtask : t_slow

	task automatic t_fast;
		set_mode(3'h5, MODE_BOOT);
		set_mode(MODE_MAX, MODE_MAX);
		run(1'b1, 5'h16, 8'h5A, 1, 2, 1'b1);
		check("wait_seen", {15'h0, waits > 0}, 16'h1);
		check("rd_data", {8'h0, q}, 16'h005A);
		check("rd_addr", {11'h0, rd_addr}, 16'h0016);
		run(1'b0, 5'h16, 8'hC3, 1, 1, 1'b1);
		check("wr_word", {3'h0, wr_addr, wr_data}, 16'h16C3);
		set_mode(MODE_FAST_MIN, MODE_FAST_MIN);
		run(1'b1, 5'h11, 8'h96, 1, 1, 1'b1);
		check("rd_data", {8'h0, q}, 16'h0096);
	endtask : t_fast

	task automatic t_dmack;
		set_mode(MODE_BOOT, MODE_BOOT);
		run(1'b1, 5'h15, 8'h77, 8, 1, 1'b0);
		check("rd_cnt", 16'(rd_cnt), 16'h3);
		check("dd_oe", {15'h0, dd_oe}, 16'h0);
		check("dmack_bus", {8'h0, q}, 16'h0088);
	endtask : t_dmack

	// User answers far too late: IORDY must come back within its pulse ceiling
	task automatic t_timeout;
		set_mode(MODE_MAX, MODE_MAX);
		run(1'b1, 5'h0D, 8'h44, 1, 30, 1'b1);
		check("tout_waits", 16'(waits), 16'(WAIT_MAX_CYC - 4'h1));
		check("tout_rd_cnt", 16'(rd_cnt), 16'h4);
		check("tout_addr", {11'h0, rd_addr}, 16'h000D);
		check("tout_dd_oe", {15'h0, dd_oe}, 16'h0);
	endtask : t_timeout

	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		t_reset();
		t_slow();
		t_fast();
		t_dmack();
		t_timeout();
		end_sim();
	end
endmodule : tb_pio_register_transfer_timing
